// ---- rtl/dual_group_gp_timer.sv ----
/*
 * Five 16-bit timers in two groups with capture, reload and toggle latches,
 * reached over APB. Assumes one 10 MHz clock, synchronous pins and an APB
 * master that holds each request until pready.
 */
// Overview of operation
// (RULE1) Five 16-bit timers, groups A and B
// (RULE2) Group A: timer, gated, counter, encoder modes
// (RULE3) Timer mode counts prescaled clock ticks
// (RULE4) Counter mode counts timer input pin edges
// (RULE5) Gated mode counts ticks while gate active
// (RULE6) Group A finest step is four clocks
// (RULE7) Direction from control bit, optionally pin
// (RULE8) Encoder mode decodes quadrature on two pins
// (RULE9) Group A latch toggles on core wrap
// (RULE10) Group A latch can clock aux timers
// (RULE11) Capture or reload aux timer stops counting
// (RULE12) Aux capture latches core on pin edge
// (RULE13) Core reloads from aux on pin/latch edge
// (RULE14) Opposite latch edges reload alternately for PWM
// (RULE15) Group B finest step is two clocks
// (RULE16) Group B clocked by prescaler or pins
// (RULE17) Group B latch toggles, clocks aux, drives pin
// (RULE18) Group B core wrap reloads and is exported
// (RULE19) Capture register latches aux B on edge
// (RULE20) Optional clear of aux B after capture
// (RULE21) Capture trigger may come from core A inputs
// (RULE22) Wrap modulo 65536 sets a sticky flag
// (RULE23) Pins synchronised before any edge detection
`timescale 1ns/1ns
module dual_group_gp_timer
    import gp_timer_pkg::*;
(
    input  wire logic        mclk,                   // System clock, 10 MHz
    input  wire logic        reset,                  // Synchronous reset, active high
    input  wire apb_req_type apb_req,                // APB request signals
    output apb_rsp_type      apb_rsp,                // APB answer signals
    input  wire pins_type    pins,                   // Timer, direction, capture pins
    output logic             group_a_toggle_output,  // Group A toggle latch pin
    output logic             group_b_toggle_output,  // Group B toggle latch pin
    output logic             group_b_wrap_clock      // Pulse on group B core wrap
);
    state_type             s;
    state_type             next_s;
    pins_type              lvl;
    pins_type              prv;
    pins_type              rise;
    pins_type              fall;
    logic [NUM_TIMERS-1:0] inc;
    logic [NUM_TIMERS-1:0] down;
    logic [NUM_TIMERS-1:0] wrap;
    logic [NUM_TIMERS-1:0] cap_hit;
    logic [NUM_TIMERS-1:0] rel_hit;
    logic [NUM_TIMERS-1:0][15:0] stepped;
    logic                  a_tgl_rise;
    logic                  a_tgl_fall;
    logic                  b_tgl_rise;
    logic                  b_tgl_fall;
    logic                  b_cap_hit;
    logic                  wr;
    logic                  setup;

    // Selected transition present
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        return (sel[0] & r) | (sel[1] & f);
    endfunction : edge_hit

    // Pin synchroniser and edge detection on synchronised samples
    pin_sync u_sync (
        .mclk  (mclk),
        .reset (reset),
        .raw   (pins),
        .level (lvl),
        .prev  (prv)
    );
    assign rise = lvl & ~prv; // RULE23
    assign fall = ~lvl & prv; // RULE23

    // Bus phase decode
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr    = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;

    // Toggle latch transitions, seen in the cycle of the wrap
    assign a_tgl_rise = wrap[IDX_A_CORE] && !s.tgl_a;
    assign a_tgl_fall = wrap[IDX_A_CORE] && s.tgl_a;
    assign b_tgl_rise = wrap[IDX_B_CORE] && !s.tgl_b;
    assign b_tgl_fall = wrap[IDX_B_CORE] && s.tgl_b;

    // Capture trigger source for the group B capture/reload register
    always_comb begin
        unique case (s.cap_ctl.src)
            2'b00: b_cap_hit = edge_hit(s.cap_ctl.edge_sel, rise.cap, fall.cap); // RULE19
            2'b01: b_cap_hit = edge_hit(s.cap_ctl.edge_sel, rise.tin[IDX_A_CORE],
                                        fall.tin[IDX_A_CORE]); // RULE21
            2'b10: b_cap_hit = edge_hit(s.cap_ctl.edge_sel, rise.dir[IDX_A_CORE],
                                        fall.dir[IDX_A_CORE]); // RULE21
            2'b11: b_cap_hit = edge_hit(s.cap_ctl.edge_sel,
                                        rise.tin[IDX_A_CORE] | rise.dir[IDX_A_CORE],
                                        fall.tin[IDX_A_CORE] | fall.dir[IDX_A_CORE]); // RULE21
        endcase
    end

    // Per-timer count enable, direction and step
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        localparam logic [DIV_W-1:0] STEP = (i < NUM_GROUP_A) ? DIV_W'(A_STEP_CLOCKS)
                                                              : DIV_W'(B_STEP_CLOCKS);
        localparam bit IS_A_AUX = (i == IDX_A_LOW) || (i == IDX_A_HIGH);
        localparam bit IS_AUX   = IS_A_AUX || (i == IDX_B_AUX);
        ctl_type c;
        logic    tick;
        logic    pin_ev;
        logic    link_ev;
        logic    enc_any;
        logic    enc_down;
        logic    step_i;

        assign c = s.ctl[i];
        // One tick every STEP times two to the ps clocks
        assign tick = c.run && ((s.div & ((STEP << c.ps) - DIV_W'(1))) == '0); // RULE6 RULE15
        assign pin_ev  = edge_hit(c.edge_sel, rise.tin[i], fall.tin[i]);
        // Aux timers may count edges of their group's toggle latch
        assign link_ev = (i == IDX_B_AUX) ? edge_hit(c.edge_sel, b_tgl_rise, b_tgl_fall) // RULE17
                                          : edge_hit(c.edge_sel, a_tgl_rise, a_tgl_fall); // RULE10
        // Quadrature: any edge on A or B counts, phase gives direction
        assign enc_any  = rise.tin[i] | fall.tin[i] | rise.dir[i] | fall.dir[i];
        assign enc_down = !(lvl.tin[i] ^ prv.dir[i]); // RULE8

        assign cap_hit[i] = IS_A_AUX && (c.mode == MODE_CAPTURE) && pin_ev; // RULE12
        assign rel_hit[i] = IS_A_AUX && (c.mode == MODE_RELOAD)
                            && (c.opt ? link_ev : pin_ev); // RULE13 RULE14

        // Count enable by mode
        always_comb begin
            unique case (c.mode)
                MODE_TIMER:     step_i = tick; // RULE3 RULE16
                MODE_COUNTER:   step_i = c.run && ((c.link && IS_AUX) ? link_ev
                                                                      : pin_ev); // RULE4 RULE16
                MODE_GATE_LOW:  step_i = tick && !lvl.tin[i]; // RULE5
                MODE_GATE_HIGH: step_i = tick && lvl.tin[i]; // RULE5
                MODE_ENCODER:   step_i = c.run && enc_any; // RULE8
                MODE_RELOAD:    step_i = 1'b0; // RULE11
                MODE_CAPTURE:   step_i = 1'b0; // RULE11
                default:        step_i = 1'b0;
            endcase
            // Group B knows only timer and counter modes
            if (i >= NUM_GROUP_A && c.mode != MODE_TIMER && c.mode != MODE_COUNTER) begin
                step_i = 1'b0;
            end
        end

        assign inc[i]  = step_i; // RULE2
        assign down[i] = (c.mode == MODE_ENCODER) ? enc_down
                                                  : c.down ^ (c.xdir & lvl.dir[i]); // RULE7

        count_step u_step (
            .value      (s.tmr[i]),
            .step       (step_i),
            .down       (down[i]),
            .next_value (stepped[i]),
            .wrap       (wrap[i])
        ); // RULE1
    end

    // Next state: counting, linkage, bus writes, flags and bus answer
    always_comb begin
        logic [31:0]           rdata;
        logic                  hit;
        logic [NUM_TIMERS-1:0] clr;
        rdata  = 32'h0000_0000;
        hit    = 1'b0;
        clr    = '0;
        next_s = s;
        next_s.div = s.div + DIV_W'(1);
        next_s.tmr = stepped;

        // Aux capture of the group A core timer
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (cap_hit[i]) begin
                next_s.tmr[i] = s.tmr[IDX_A_CORE]; // RULE12
            end
        end
        // Reload of the group A core timer; the low aux wins a tie
        for (int i = NUM_TIMERS - 1; i >= 0; i--) begin
            if (rel_hit[i]) begin
                next_s.tmr[IDX_A_CORE] = s.tmr[i]; // RULE13 RULE14
            end
        end

        // Toggle latches and the exported wrap pulse
        next_s.tgl_a  = s.tgl_a ^ wrap[IDX_A_CORE]; // RULE9
        next_s.tgl_b  = s.tgl_b ^ wrap[IDX_B_CORE]; // RULE17
        next_s.b_wrap = wrap[IDX_B_CORE]; // RULE18
        if (wrap[IDX_B_CORE] && s.ctl[IDX_B_CORE].opt) begin
            next_s.tmr[IDX_B_CORE] = s.cr; // RULE18
        end

        // Capture of group B aux timer, with optional clear
        if (b_cap_hit) begin
            next_s.cr = s.tmr[IDX_B_AUX]; // RULE19
            if (s.cap_ctl.clear) begin
                next_s.tmr[IDX_B_AUX] = 16'h0000; // RULE20
            end
        end

        // Software writes take the access-phase edge and win over counting
        if (wr) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (apb_req.paddr == OFF_CTL_BASE + 8'(4 * i)) begin
                    next_s.ctl[i] = ctl_type'(apb_req.pwdata[15:0]);
                end
                if (apb_req.paddr == OFF_TMR_BASE + 8'(4 * i)) begin
                    next_s.tmr[i] = apb_req.pwdata[15:0];
                end
            end
            if (apb_req.paddr == OFF_CR) begin
                next_s.cr = apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == OFF_CAP_CTL) begin
                next_s.cap_ctl = cap_ctl_type'(apb_req.pwdata[4:0]);
            end
            if (apb_req.paddr == OFF_FLAGS) begin
                clr = apb_req.pwdata[NUM_TIMERS-1:0];
            end
        end

        // Sticky wrap flags: write one to clear, a new wrap wins
        next_s.flags = (s.flags & ~clr) | wrap; // RULE22

        // Toggle pins follow the latch when enabled
        next_s.a_out = next_s.tgl_a & next_s.ctl[IDX_A_CORE].link; // RULE9
        next_s.b_out = next_s.tgl_b & next_s.ctl[IDX_B_CORE].link; // RULE17

        // Read mux
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (apb_req.paddr == OFF_CTL_BASE + 8'(4 * i)) begin
                rdata = {16'h0000, s.ctl[i]};
                hit   = 1'b1;
            end
            if (apb_req.paddr == OFF_TMR_BASE + 8'(4 * i)) begin
                rdata = {16'h0000, s.tmr[i]};
                hit   = 1'b1;
            end
        end
        if (apb_req.paddr == OFF_CR) begin
            rdata = {16'h0000, s.cr};
            hit   = 1'b1;
        end
        if (apb_req.paddr == OFF_FLAGS) begin
            rdata = {27'h0000000, s.flags};
            hit   = 1'b1;
        end
        if (apb_req.paddr == OFF_CAP_CTL) begin
            rdata = {27'h0000000, s.cap_ctl};
            hit   = 1'b1;
        end

        // Answer: ready in the first access cycle, error on unmapped address
        next_s.rsp.pready  = setup;
        next_s.rsp.pslverr = setup && !hit;
        if (setup) begin
            next_s.rsp.prdata = (apb_req.pwrite || !hit) ? 32'h0000_0000 : rdata;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from state flip-flops
    assign apb_rsp               = s.rsp;
    assign group_a_toggle_output = s.a_out;
    assign group_b_toggle_output = s.b_out;
    assign group_b_wrap_clock    = s.b_wrap;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence core_tick_s;
        s.ctl[IDX_A_CORE].mode == MODE_TIMER && inc[IDX_A_CORE];
    endsequence

    sequence b_tick_s;
        s.ctl[IDX_B_CORE].mode == MODE_TIMER && inc[IDX_B_CORE];
    endsequence

    a_core_step_four: assert property (core_tick_s |=> !inc[IDX_A_CORE] [*3]) // RULE6
        else $error("group A core stepped sooner than four clocks");

    a_b_step_two: assert property (b_tick_s |=> !inc[IDX_B_CORE]) // RULE15
        else $error("group B core stepped sooner than two clocks");

    a_gate_closed: assert property ((s.ctl[IDX_A_CORE].mode == MODE_GATE_HIGH
        && !lvl.tin[IDX_A_CORE]) |-> !inc[IDX_A_CORE]) // RULE5
        else $error("gated core counted with gate closed");

    a_latch_flips: assert property (wrap[IDX_A_CORE]
        |=> s.tgl_a != $past(s.tgl_a)) // RULE9
        else $error("group A toggle latch missed a wrap");

    a_aux_stopped: assert property ((s.ctl[IDX_A_HIGH].mode == MODE_RELOAD) && !wr
        |=> s.tmr[IDX_A_HIGH] == $past(s.tmr[IDX_A_HIGH])) // RULE11
        else $error("reload aux timer moved");

    a_aux_capture: assert property (cap_hit[IDX_A_LOW] && !wr
        |=> s.tmr[IDX_A_LOW] == $past(s.tmr[IDX_A_CORE])) // RULE12
        else $error("aux capture missed the core value");

    a_core_reload: assert property (rel_hit[IDX_A_HIGH] && !rel_hit[IDX_A_LOW] && !wr
        |=> s.tmr[IDX_A_CORE] == $past(s.tmr[IDX_A_HIGH])) // RULE13
        else $error("core not reloaded from aux");

    a_b_capture_clear: assert property (b_cap_hit && s.cap_ctl.clear && !wr
        |=> s.cr == $past(s.tmr[IDX_B_AUX]) && s.tmr[IDX_B_AUX] == 16'h0000) // RULE20
        else $error("group B capture or clear wrong");

    a_wrap_flag: assert property (wrap[IDX_A_CORE] |=> s.flags[IDX_A_CORE]) // RULE22
        else $error("wrap flag not set");

    a_b_wrap_export: assert property (wrap[IDX_B_CORE] |=> group_b_wrap_clock) // RULE18
        else $error("group B wrap pulse missing");

    a_b_latch_flips: assert property (wrap[IDX_B_CORE] |=> s.tgl_b != $past(s.tgl_b)) // RULE17
        else $error("group B toggle latch missed a wrap");

    a_b_core_reload: assert property (wrap[IDX_B_CORE] && s.ctl[IDX_B_CORE].opt && !wr
        |=> s.tmr[IDX_B_CORE] == $past(s.cr)) // RULE18
        else $error("group B core not reloaded on wrap");

    a_b_pin_follows: assert property (s.ctl[IDX_B_CORE].link && !wr
        |=> group_b_toggle_output == s.tgl_b) // RULE17
        else $error("group B toggle pin differs from latch");

    a_a_pin_off: assert property (!s.ctl[IDX_A_CORE].link && !wr
        |=> !group_a_toggle_output) // RULE9
        else $error("group A toggle pin high while disabled");

endmodule : dual_group_gp_timer

// ---- rtl/gp_timer_pkg.sv ----
/*
 * Shared constants, register map and carrier types for the dual group timer unit.
 * Assumes a single 10 MHz clock, APB register access with 32-bit data and
 * pin inputs that are synchronous to that clock.
 */
package gp_timer_pkg;

    // Timer population and slot numbers
    localparam int NUM_TIMERS  = 5;
    localparam int NUM_GROUP_A = 3;
    localparam int IDX_A_LOW   = 0;
    localparam int IDX_A_CORE  = 1;
    localparam int IDX_A_HIGH  = 2;
    localparam int IDX_B_AUX   = 3;
    localparam int IDX_B_CORE  = 4;

    // Timing: clock rate and finest counting step of each group
    localparam int CLOCK_HZ      = 10_000_000;
    localparam int A_STEP_CLOCKS = 4;
    localparam int B_STEP_CLOCKS = 2;
    localparam int DIV_W         = 10;

    // Register byte offsets
    localparam logic [7:0] OFF_CTL_BASE = 8'h00;
    localparam logic [7:0] OFF_TMR_BASE = 8'h14;
    localparam logic [7:0] OFF_CR       = 8'h28;
    localparam logic [7:0] OFF_FLAGS    = 8'h2C;
    localparam logic [7:0] OFF_CAP_CTL  = 8'h30;

    // Operating modes of one timer
    typedef enum logic [2:0] {
        MODE_TIMER     = 3'b000,
        MODE_COUNTER   = 3'b001,
        MODE_GATE_LOW  = 3'b010,
        MODE_GATE_HIGH = 3'b011,
        MODE_RELOAD    = 3'b100,
        MODE_CAPTURE   = 3'b101,
        MODE_ENCODER   = 3'b110
    } mode_type;

    // Per-timer control word, low 16 bits of its register
    typedef struct packed {
        logic [2:0] spare;     // Reads back as written
        logic       opt;       // Aux A: reload on latch edge; core B: reload on wrap
        logic       link;      // Aux: count latch edges; core: drive toggle pin
        logic [1:0] edge_sel;  // Bit 0 rising, bit 1 falling
        logic       xdir;      // Direction pin may invert the count direction
        logic       down;      // Count down
        logic       run;       // Counting enabled
        mode_type   mode;      // Operating mode
        logic [2:0] ps;        // Prescaler exponent
    } ctl_type;

    // Capture control of the group B capture/reload register
    typedef struct packed {
        logic       clear;     // Clear group B aux timer after capture
        logic [1:0] src;       // 0 capture pin, 1 core count in, 2 core dir in, 3 both
        logic [1:0] edge_sel;  // Bit 0 rising, bit 1 falling
    } cap_ctl_type;

    // External pins, slot-indexed like the timers
    typedef struct packed {
        logic                  cap;
        logic [NUM_TIMERS-1:0] dir;
        logic [NUM_TIMERS-1:0] tin;
    } pins_type;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic [NUM_TIMERS-1:0][15:0] tmr;
        ctl_type [NUM_TIMERS-1:0]    ctl;
        cap_ctl_type                 cap_ctl;
        logic [15:0]                 cr;
        logic [NUM_TIMERS-1:0]       flags;
        logic                        tgl_a;
        logic                        tgl_b;
        logic                        a_out;
        logic                        b_out;
        logic                        b_wrap;
        logic [DIV_W-1:0]            div;
        apb_rsp_type                 rsp;
    } state_type;

    // Reset values
    localparam state_type STATE_RESET = '0;

endpackage : gp_timer_pkg

// ---- rtl/pin_sync.sv ----
/*
 * Two-stage synchroniser for all timer pins plus one more stage kept for
 * edge detection. Assumes pins change no faster than the clock samples them.
 */
`timescale 1ns/1ns
module pin_sync
    import gp_timer_pkg::*;
(
    input  wire logic     mclk,   // System clock
    input  wire logic     reset,  // Synchronous reset, active high
    input  wire pins_type raw,    // Pins as they arrive
    output pins_type      level,  // Synchronised level
    output pins_type      prev    // Level one clock earlier
);
    typedef struct packed {
        pins_type meta;
        pins_type level;
        pins_type prev;
    } sync_state_type;

    sync_state_type s;
    sync_state_type next_s;

    // Chain: only the second stage reads the first
    always_comb begin
        next_s.meta  = raw;
        next_s.level = s.meta;
        next_s.prev  = s.level;
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s; // RULE23
        end
    end

    assign level = s.level;
    assign prev  = s.prev;

endmodule : pin_sync

// ---- rtl/count_step.sv ----
/*
 * One step of a 16-bit up/down counter with wrap detection.
 * Pure combinational; the caller holds the count.
 */
`timescale 1ns/1ns
module count_step
    import gp_timer_pkg::*;
(
    input  wire logic [15:0] value,       // Present count
    input  wire logic        step,        // Advance this cycle
    input  wire logic        down,        // Count down when high
    output logic      [15:0] next_value,  // Count after the step
    output logic             wrap         // Overflow or underflow this cycle
);
    // Wraps modulo 65536 in either direction
    always_comb begin
        next_value = value;
        wrap       = 1'b0;
        if (step) begin
            next_value = down ? value - 16'h0001 : value + 16'h0001; // RULE22
            wrap       = down ? (value == 16'h0000) : (value == 16'hFFFF);
        end
    end

endmodule : count_step

// ---- bench/pin_partner.sv ----
/*
 * Far-side model of the timer pins: event pulses, capture pulses and a
 * quadrature position encoder. Assumes the bench clock and calls from the bench.
 */
`timescale 1ns/1ns
module pin_partner
    import gp_timer_pkg::*;
(
    input  wire logic mclk,  // System clock
    output pins_type  pins   // Pin levels towards the unit
);
    int         ph;
    logic [1:0] seq [4];

    // Encoder phase table, signal A then B; pins idle low
    initial begin
        seq  = '{2'b00, 2'b10, 2'b11, 2'b01};
        ph   = 0;
        pins = '0;
    end

    // Event pulses on one timer input, with a chosen hold in cycles
    task automatic pulse_tin(input int slot, input int n, input int hold);
        repeat (n) begin
            @(posedge mclk);
            pins.tin[slot] <= 1'b1;
            repeat (hold) @(posedge mclk);
            pins.tin[slot] <= 1'b0;
            repeat (hold) @(posedge mclk);
        end
    endtask : pulse_tin

    // One rising then falling transition of the capture input
    task automatic pulse_cap();
        @(posedge mclk);
        pins.cap <= 1'b1;
        repeat (4) @(posedge mclk);
        pins.cap <= 1'b0;
    endtask : pulse_cap

    // Quadrature steps on the core A input and direction pins
    task automatic quad(input logic fwd, input int n);
        repeat (n) begin
            @(posedge mclk);
            ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
            pins.tin[1] <= seq[ph][1];
            pins.dir[1] <= seq[ph][0];
            repeat (4) @(posedge mclk);
        end
    endtask : quad
endmodule : pin_partner

// ---- bench/tb_dual_group_gp_timer.sv ----
/*
 * Self-checking bench for the dual group timer unit: APB master tasks and
 * one task per scenario. Assumes zero-wait APB and the pin partner model.
 */
`timescale 1ns/1ns
module tb_dual_group_gp_timer;
    import gp_timer_pkg::*;

    logic        mclk;
    logic        reset;
    apb_req_type apb_req;
    apb_rsp_type apb_rsp;
    pins_type    pins;
    logic        a_out;
    logic        b_out;
    logic        b_wrap;
    int          n_fail;
    int          n_bwrap;
    int          cmp_count;
    int          cyc;
    logic [31:0] rd;
    logic        err;

    dual_group_gp_timer i_dut (
        .mclk                  (mclk),
        .reset                 (reset),
        .apb_req               (apb_req),
        .apb_rsp               (apb_rsp),
        .pins                  (pins),
        .group_a_toggle_output (a_out),
        .group_b_toggle_output (b_out),
        .group_b_wrap_clock    (b_wrap)
    );

    pin_partner i_pins (
        .mclk (mclk),
        .pins (pins)
    );

    // Clock and hang guard
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // Count exported group B wrap pulses
    always @(posedge mclk) begin
        if (b_wrap === 1'b1) begin
            n_bwrap <= n_bwrap + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        apb_req.paddr   <= a;
        apb_req.pwrite  <= wr;
        apb_req.pwdata  <= wd;
        apb_req.psel    <= 1'b1;
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cw(mode_type m, logic run, logic [1:0] es, logic lk);
        return {19'h0, 1'b0, lk, es, 1'b0, 1'b0, run, m, 3'h0};
    endfunction : cw

    task automatic t_reset_map();
        apb(1'b0, OFF_TMR_BASE + 8'h04, 0);
        check(rd, 32'h0);
        apb(1'b0, OFF_FLAGS, 0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test reset_map done");
    endtask : t_reset_map

    task automatic t_rate();
        apb(1'b1, OFF_TMR_BASE + 8'h04, 0);
        apb(1'b1, OFF_CTL_BASE + 8'h04, cw(MODE_TIMER, 1'b1, 2'b00, 1'b0));
        repeat (40) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE + 8'h04, 0);
        check(rd >= 32'd9 && rd <= 32'd12, 1'b1);
        apb(1'b1, OFF_CTL_BASE + 8'h04, 0);
        $display("test rate done");
    endtask : t_rate

    task automatic t_wrap();
        apb(1'b1, OFF_TMR_BASE + 8'h04, 32'h0000FFFE);
        apb(1'b1, OFF_CTL_BASE + 8'h04, cw(MODE_TIMER, 1'b1, 2'b00, 1'b1));
        repeat (20) @(posedge mclk);
        apb(1'b0, OFF_FLAGS, 0);
        check(rd[1], 1'b1);
        check(a_out, 1'b1);
        apb(1'b1, OFF_FLAGS, 32'h00000002);
        apb(1'b0, OFF_FLAGS, 0);
        check(rd[1], 1'b0);
        apb(1'b1, OFF_CTL_BASE + 8'h04, 0);
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_counter();
        apb(1'b1, OFF_TMR_BASE, 0);
        apb(1'b1, OFF_CTL_BASE, cw(MODE_COUNTER, 1'b1, 2'b01, 1'b0));
        i_pins.pulse_tin(0, 5, 3);
        repeat (6) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE, 0);
        check(rd, 32'd5);
        $display("test counter done");
    endtask : t_counter

    task automatic t_encoder();
        apb(1'b1, OFF_TMR_BASE + 8'h04, 32'h00000100);
        apb(1'b1, OFF_CTL_BASE + 8'h04, cw(MODE_ENCODER, 1'b1, 2'b11, 1'b0));
        i_pins.quad(1'b1, 8);
        repeat (6) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE + 8'h04, 0);
        check(rd, 32'h00000108);
        i_pins.quad(1'b0, 8);
        repeat (6) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE + 8'h04, 0);
        check(rd, 32'h00000100);
        $display("test encoder done");
    endtask : t_encoder

    task automatic t_capture();
        apb(1'b1, OFF_TMR_BASE + 8'h0C, 32'h00001234);
        apb(1'b1, OFF_CAP_CTL, 32'h00000011);
        i_pins.pulse_cap();
        repeat (8) @(posedge mclk);
        apb(1'b0, OFF_CR, 0);
        check(rd, 32'h00001234);
        apb(1'b0, OFF_TMR_BASE + 8'h0C, 0);
        check(rd, 32'h0);
        $display("test capture done");
    endtask : t_capture

    task automatic t_link();
        apb(1'b1, OFF_TMR_BASE + 8'h04, 32'h00000ABC);
        apb(1'b1, OFF_CTL_BASE, cw(MODE_CAPTURE, 1'b0, 2'b01, 1'b0));
        apb(1'b1, OFF_TMR_BASE + 8'h08, 32'h00000555);
        apb(1'b1, OFF_CTL_BASE + 8'h08, cw(MODE_RELOAD, 1'b1, 2'b01, 1'b0));
        i_pins.pulse_tin(0, 1, 3);
        i_pins.pulse_tin(2, 1, 3);
        repeat (6) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE, 0);
        check(rd, 32'h00000ABC);
        apb(1'b0, OFF_TMR_BASE + 8'h04, 0);
        check(rd, 32'h00000555);
        apb(1'b0, OFF_TMR_BASE + 8'h08, 0);
        check(rd, 32'h00000555);
        $display("test link done");
    endtask : t_link

    task automatic t_group_b();
        apb(1'b1, OFF_CR, 32'h0000FFF0);
        apb(1'b1, OFF_TMR_BASE + 8'h10, 32'h0000FFFE);
        apb(1'b1, OFF_CTL_BASE + 8'h10, 32'h00001840);
        repeat (20) @(posedge mclk);
        apb(1'b0, OFF_TMR_BASE + 8'h10, 0);
        check(rd[15:4], 12'hFFF);
        check(n_bwrap, 1);
        check(b_out, 1'b1);
        apb(1'b0, OFF_FLAGS, 0);
        check(rd[4], 1'b1);
        apb(1'b1, OFF_CTL_BASE + 8'h10, 0);
        $display("test group_b done");
    endtask : t_group_b

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        apb_req   = '0;
        reset     = 1'b1;
        n_fail    = 0;
        cmp_count = 0;
        n_bwrap   = 0;
        cyc       = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_reset_map();
        t_rate();
        t_wrap();
        t_counter();
        t_encoder();
        t_capture();
        t_link();
        t_group_b();
        wrap_up();
    end
endmodule : tb_dual_group_gp_timer
